// ==== common/sad_regs.vh ====
// Purpose: Address map constants for the system address decoder.
// Assumes: 32-bit byte addresses; a region matches when (addr & ~MASK) == BASE.
// Notes: Target codes are shared by both master result ports.
`ifndef SAD_REGS_VH
`define SAD_REGS_VH

// Target codes.
`define SAD_T_ERROR 4'h0
`define SAD_T_FLASH 4'h1
`define SAD_T_SRAM 4'h2
`define SAD_T_BOOT 4'h3
`define SAD_T_PSRAM0_LO 4'h4
`define SAD_T_PSRAM0_HI 4'h5
`define SAD_T_PSRAM1 4'h6
`define SAD_T_FASTPER 4'h7
`define SAD_T_SLOWPER0 4'h8
`define SAD_T_SLOWPER1 4'h9
`define SAD_T_STATIC 4'hA
`define SAD_T_DYNAMIC 4'hB
`define SAD_T_PRIVATE 4'hC

// Fitted-size windows; the top offset above BASE is (SMALLEST << size code) - 1, the SRAM code capped at SAD_SRAM_SIZE_MAX.
`define SAD_FLASH_BASE 32'h00000000
`define SAD_FLASH_SMALLEST 32'h00010000
`define SAD_SRAM_BASE 32'h10000000
`define SAD_SRAM_SMALLEST 32'h00004000
`define SAD_SRAM_SIZE_MAX 2'h2

// Fixed windows.
`define SAD_BOOT_BASE 32'h1FFF0000
`define SAD_BOOT_MASK 32'h00001FFF
`define SAD_PSRAM0_LO_BASE 32'h20000000
`define SAD_PSRAM0_HI_BASE 32'h20002000
`define SAD_PSRAM0_MASK 32'h00001FFF
`define SAD_PSRAM1_BASE 32'h20004000
`define SAD_PSRAM1_MASK 32'h00003FFF
`define SAD_FASTPER_BASE 32'h20080000
`define SAD_FASTPER_MASK 32'h0003FFFF
`define SAD_SLOWPER0_BASE 32'h40000000
`define SAD_SLOWPER1_BASE 32'h40080000
`define SAD_SLOWPER_MASK 32'h0007FFFF
`define SAD_PRIVATE_BASE 32'hE0000000
`define SAD_PRIVATE_MASK 32'h000FFFFF

// Peripheral slots are 16 kB each.
`define SAD_SLOT_MASK 32'h00003FFF

// External static chip select windows, 64 MB each.
`define SAD_STATIC0_BASE 32'h80000000
`define SAD_STATIC1_BASE 32'h90000000
`define SAD_STATIC2_BASE 32'h98000000
`define SAD_STATIC3_BASE 32'h9C000000
`define SAD_STATIC_MASK 32'h03FFFFFF

// External dynamic chip select windows, 256 MB each.
`define SAD_DYNAMIC_FIRST 4'hA
`define SAD_DYNAMIC_LAST 4'hD
`define SAD_DYNAMIC_MASK 32'h0FFFFFFF
`define SAD_DYNAMIC_CS_ADJ 2'h2

// Vector remap targets.
`define SAD_REMAP_BOOT 2'h0
`define SAD_REMAP_SRAM 2'h1
`define SAD_VEC_BYTES 32'h00000200

`endif

// ==== rtl/sad_decoder.v ====
// Purpose: System address decoder and per-slave arbiter for two bus masters.
// Assumes: Masters hold a request and its address until it is accepted.
// Notes: Results appear one cycle after a request is taken.
// Summary of operation
// [RQ1] Flash from zero, top set by size.
// [RQ2] Main SRAM at 0x10000000, sized window.
// [RQ3] Boot ROM 0x1FFF0000 to 0x1FFF1FFF.
// [RQ4] Peripheral SRAM bank 0 halves, bank 1.
// [RQ5] Fast peripheral region 0x20080000 to 0x200BFFFF.
// [RQ6] Fast area is 16 slots in 256 kB.
// [RQ7] First slow bus 0x40000000 to 0x4007FFFF.
// [RQ8] Second slow bus 0x40080000 to 0x400FFFFF.
// [RQ9] Slow area is 64 slots in 1 MB.
// [RQ10] Each peripheral gets a 16 kB slot.
// [RQ11] Four static chip selects, 64 MB each.
// [RQ12] Four dynamic chip selects, 256 MB each.
// [RQ13] Private core region 0xE0000000 to 0xE00FFFFF.
// [RQ14] Vector area can be remapped elsewhere.
// [RQ15] Masters run concurrently; arbitrate same slave only.
// [RQ16] Unmapped or unfitted addresses give bus error.
`timescale 1ns/1ps
`include "sad_regs.vh"

// Decodes one master's address into target, chip select, slot and offset.
module sad_addr_decode #(
  parameter [31:0] VEC_BYTES = `SAD_VEC_BYTES
) (
  // Address under decode.
  input wire [31:0] addr_in,
  // Fitted configuration and remap control.
  input wire [1:0] flash_size_in,
  input wire [1:0] sram_size_in,
  input wire remap_en_in,
  input wire [1:0] remap_sel_in,
  // Decode result, settled in the same cycle.
  output wire [3:0] target_out,
  output wire [1:0] cs_out,
  output wire [6:0] slot_out,
  output wire [31:0] offset_out
);

  // Tests whether an address lies in an aligned window.
  function in_win;
    input [31:0] a;
    input [31:0] base;
    input [31:0] mask;
    begin
      in_win = ((a & ~mask) == base);
    end
  endfunction

  // Decodes one address to {target, chip select, slot, offset}.
  function [44:0] sad_decode;
    input [31:0] a;
    input [1:0] fsz;
    input [1:0] ssz;
    input remap_en;
    input [1:0] remap_sel;
    reg [3:0] t;
    reg [1:0] cs;
    reg [6:0] slot;
    reg [31:0] off;
    reg [31:0] flim;
    reg [31:0] slim;
    reg [1:0] ssz_c;
    begin
      t = `SAD_T_ERROR;
      cs = 2'h0;
      slot = 7'h00;
      off = 32'h00000000;
      ssz_c = (ssz > `SAD_SRAM_SIZE_MAX) ? `SAD_SRAM_SIZE_MAX : ssz;
      flim = (`SAD_FLASH_SMALLEST << fsz) - 32'h00000001;
      slim = (`SAD_SRAM_SMALLEST << ssz_c) - 32'h00000001;
      if (remap_en && (a < VEC_BYTES)) begin
        // Vector fetches are redirected, keeping the offset.
        off = a; // RQ14
        if (remap_sel == `SAD_REMAP_BOOT) begin
          t = `SAD_T_BOOT;
        end else if (remap_sel == `SAD_REMAP_SRAM) begin
          t = `SAD_T_SRAM;
        end else begin
          t = `SAD_T_FLASH;
        end
      end else if (in_win(a, `SAD_FLASH_BASE, flim)) begin
        t = `SAD_T_FLASH; // RQ1
        off = a & flim;
      end else if (in_win(a, `SAD_SRAM_BASE, slim)) begin
        t = `SAD_T_SRAM; // RQ2
        off = a & slim;
      end else if (in_win(a, `SAD_BOOT_BASE, `SAD_BOOT_MASK)) begin
        t = `SAD_T_BOOT; // RQ3
        off = a & `SAD_BOOT_MASK;
      end else if (in_win(a, `SAD_PSRAM0_LO_BASE, `SAD_PSRAM0_MASK)) begin
        t = `SAD_T_PSRAM0_LO; // RQ4
        off = a & `SAD_PSRAM0_MASK;
      end else if (in_win(a, `SAD_PSRAM0_HI_BASE, `SAD_PSRAM0_MASK)) begin
        t = `SAD_T_PSRAM0_HI; // RQ4
        off = a & `SAD_PSRAM0_MASK;
      end else if (in_win(a, `SAD_PSRAM1_BASE, `SAD_PSRAM1_MASK)) begin
        t = `SAD_T_PSRAM1; // RQ4
        off = a & `SAD_PSRAM1_MASK;
      end else if (in_win(a, `SAD_FASTPER_BASE, `SAD_FASTPER_MASK)) begin
        t = `SAD_T_FASTPER; // RQ5
        slot = a[20:14]; // RQ6
        off = a & `SAD_SLOT_MASK; // RQ10
      end else if (in_win(a, `SAD_SLOWPER0_BASE, `SAD_SLOWPER_MASK)) begin
        t = `SAD_T_SLOWPER0; // RQ7
        slot = {1'b0, a[19:14]}; // RQ9
        off = a & `SAD_SLOT_MASK; // RQ10
      end else if (in_win(a, `SAD_SLOWPER1_BASE, `SAD_SLOWPER_MASK)) begin
        t = `SAD_T_SLOWPER1; // RQ8
        slot = {1'b0, a[19:14]}; // RQ9
        off = a & `SAD_SLOT_MASK; // RQ10
      end else if (in_win(a, `SAD_STATIC0_BASE, `SAD_STATIC_MASK)) begin
        t = `SAD_T_STATIC; // RQ11
        cs = 2'h0;
        off = a & `SAD_STATIC_MASK;
      end else if (in_win(a, `SAD_STATIC1_BASE, `SAD_STATIC_MASK)) begin
        t = `SAD_T_STATIC; // RQ11
        cs = 2'h1;
        off = a & `SAD_STATIC_MASK;
      end else if (in_win(a, `SAD_STATIC2_BASE, `SAD_STATIC_MASK)) begin
        t = `SAD_T_STATIC; // RQ11
        cs = 2'h2;
        off = a & `SAD_STATIC_MASK;
      end else if (in_win(a, `SAD_STATIC3_BASE, `SAD_STATIC_MASK)) begin
        t = `SAD_T_STATIC; // RQ11
        cs = 2'h3;
        off = a & `SAD_STATIC_MASK;
      end else if ((a[31:28] >= `SAD_DYNAMIC_FIRST) && (a[31:28] <= `SAD_DYNAMIC_LAST)) begin
        t = `SAD_T_DYNAMIC; // RQ12
        cs = a[29:28] + `SAD_DYNAMIC_CS_ADJ;
        off = a & `SAD_DYNAMIC_MASK;
      end else if (in_win(a, `SAD_PRIVATE_BASE, `SAD_PRIVATE_MASK)) begin
        t = `SAD_T_PRIVATE; // RQ13
        off = a & `SAD_PRIVATE_MASK;
      end
      // Anything left, including unfitted flash and SRAM, stays an error.
      sad_decode = {t, cs, slot, off}; // RQ16
    end
  endfunction

  // Each instance decodes one master; the result is combinational.
  assign {target_out, cs_out, slot_out, offset_out} = sad_decode(addr_in, flash_size_in,
    sram_size_in, remap_en_in, remap_sel_in);

endmodule

// Top level: two decoders, a per-slave arbiter and the registered results.
module sad_decoder #(
  parameter [31:0] VEC_BYTES = `SAD_VEC_BYTES
) (
  // Clock, reset and enable.
  input wire sys_clk_in,
  input wire rst_in,
  input wire ce_in,
  // Fitted configuration and remap control.
  input wire [1:0] flash_size_in,
  input wire [1:0] sram_size_in,
  input wire remap_en_in,
  input wire [1:0] remap_sel_in,
  // Master 0 (processor) request.
  input wire m0_req_in,
  input wire [31:0] m0_addr_in,
  // Master 1 (DMA) request.
  input wire m1_req_in,
  input wire [31:0] m1_addr_in,
  // Master 0 result.
  output reg m0_valid_out,
  output reg m0_wait_out,
  output reg m0_error_out,
  output reg [3:0] m0_target_out,
  output reg [1:0] m0_cs_out,
  output reg [6:0] m0_slot_out,
  output reg [31:0] m0_offset_out,
  // Master 1 result.
  output reg m1_valid_out,
  output reg m1_wait_out,
  output reg m1_error_out,
  output reg [3:0] m1_target_out,
  output reg [1:0] m1_cs_out,
  output reg [6:0] m1_slot_out,
  output reg [31:0] m1_offset_out,
  // External memory chip selects, one-hot, active high.
  output reg [3:0] static_mem_select_out,
  output reg [3:0] dynamic_mem_select_out
);

  // Turns a chip select index into a one-hot select when enabled.
  function [3:0] onehot;
    input en;
    input [1:0] idx;
    begin
      onehot = en ? (4'h1 << idx) : 4'h0;
    end
  endfunction

  wire [3:0] t0;
  wire [3:0] t1;
  wire [1:0] cs0;
  wire [1:0] cs1;
  wire [6:0] slot0;
  wire [6:0] slot1;
  wire [31:0] off0;
  wire [31:0] off1;
  wire conflict;
  wire grant0;
  wire grant1;
  wire err0;
  wire err1;
  reg prio_dma;

  // Both addresses are decoded in parallel every cycle.
  sad_addr_decode #(
    .VEC_BYTES(VEC_BYTES)
  ) i_dec0 (
    .addr_in(m0_addr_in),
    .flash_size_in(flash_size_in),
    .sram_size_in(sram_size_in),
    .remap_en_in(remap_en_in),
    .remap_sel_in(remap_sel_in),
    .target_out(t0),
    .cs_out(cs0),
    .slot_out(slot0),
    .offset_out(off0)
  );

  // The DMA address goes through an identical decoder.
  sad_addr_decode #(
    .VEC_BYTES(VEC_BYTES)
  ) i_dec1 (
    .addr_in(m1_addr_in),
    .flash_size_in(flash_size_in),
    .sram_size_in(sram_size_in),
    .remap_en_in(remap_en_in),
    .remap_sel_in(remap_sel_in),
    .target_out(t1),
    .cs_out(cs1),
    .slot_out(slot1),
    .offset_out(off1)
  );

  // A zero target code marks an address that nothing claims.
  assign err0 = (t0 == `SAD_T_ERROR);
  assign err1 = (t1 == `SAD_T_ERROR);

  // Only two requests for the same real slave collide; errors never do.
  assign conflict = m0_req_in & m1_req_in & (t0 == t1) & ~err0; // RQ15
  assign grant0 = m0_req_in & ~(conflict & prio_dma); // RQ15
  assign grant1 = m1_req_in & ~(conflict & ~prio_dma); // RQ15

  // A collision hands priority to the loser for the next collision.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      prio_dma <= 1'b0;
    end else if (ce_in) begin
      if (conflict) begin
        prio_dma <= ~prio_dma; // RQ15
      end
    end
  end

  // Registers the processor's result; an idle or lost cycle reads as zero except the wait flag.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      m0_valid_out <= 1'b0;
      m0_wait_out <= 1'b0;
      m0_error_out <= 1'b0;
      m0_target_out <= `SAD_T_ERROR;
      m0_cs_out <= 2'h0;
      m0_slot_out <= 7'h00;
      m0_offset_out <= 32'h00000000;
    end else if (ce_in) begin
      m0_valid_out <= grant0;
      m0_wait_out <= m0_req_in & ~grant0; // RQ15
      m0_error_out <= grant0 & err0; // RQ16
      m0_target_out <= grant0 ? t0 : `SAD_T_ERROR;
      m0_cs_out <= grant0 ? cs0 : 2'h0;
      m0_slot_out <= grant0 ? slot0 : 7'h00;
      m0_offset_out <= grant0 ? off0 : 32'h00000000;
    end
  end

  // Registers the DMA result in the same way.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      m1_valid_out <= 1'b0;
      m1_wait_out <= 1'b0;
      m1_error_out <= 1'b0;
      m1_target_out <= `SAD_T_ERROR;
      m1_cs_out <= 2'h0;
      m1_slot_out <= 7'h00;
      m1_offset_out <= 32'h00000000;
    end else if (ce_in) begin
      m1_valid_out <= grant1;
      m1_wait_out <= m1_req_in & ~grant1; // RQ15
      m1_error_out <= grant1 & err1; // RQ16
      m1_target_out <= grant1 ? t1 : `SAD_T_ERROR;
      m1_cs_out <= grant1 ? cs1 : 2'h0;
      m1_slot_out <= grant1 ? slot1 : 7'h00;
      m1_offset_out <= grant1 ? off1 : 32'h00000000;
    end
  end

  // Drives the external chip selects from either granted master.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      static_mem_select_out <= 4'h0;
      dynamic_mem_select_out <= 4'h0;
    end else if (ce_in) begin
      static_mem_select_out <= onehot(grant0 & (t0 == `SAD_T_STATIC), cs0)
        | onehot(grant1 & (t1 == `SAD_T_STATIC), cs1); // RQ11
      dynamic_mem_select_out <= onehot(grant0 & (t0 == `SAD_T_DYNAMIC), cs0)
        | onehot(grant1 & (t1 == `SAD_T_DYNAMIC), cs1); // RQ12
    end
  end

endmodule

// ==== tb/sad_decoder_properties.sv ====
// Purpose: Port checks for the system address decoder.
// Assumes: A taken request is answered on the next edge.
// Notes: Master 0 decode is checked in depth.
`timescale 1ns/1ps
module sad_decoder_chk (
  // Clock and control.
  input wire sys_clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire remap_en_in,
  // Request.
  input wire m0_req_in,
  input wire [31:0] m0_addr_in,
  // Results.
  input wire m0_valid_out,
  input wire m0_wait_out,
  input wire m0_error_out,
  input wire m1_wait_out,
  input wire [3:0] m0_target_out,
  input wire [6:0] m0_slot_out,
  input wire [3:0] static_mem_select_out,
  input wire [3:0] dynamic_mem_select_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // A plain decode request, and its address one edge later.
  wire take = ce_in && m0_req_in && !remap_en_in;
  reg [31:0] prev_addr;
  always @(posedge sys_clk_in) prev_addr <= m0_addr_in;
  chk_single_answer: assert property (ce_in && m0_req_in |=> m0_valid_out ^ m0_wait_out)
    else $error("no single answer after request");
  chk_idle_quiet: assert property (ce_in && !m0_req_in |=> !m0_valid_out && !m0_wait_out)
    else $error("answer without request");
  chk_one_loser: assert property (!(m0_wait_out && m1_wait_out))
    else $error("both masters stalled");
  chk_error_code: assert property (m0_error_out |-> m0_valid_out && m0_target_out == 4'h0)
    else $error("error without error target");
  chk_boot_target: assert property (take && m0_addr_in[31:13] == 19'h0FFF8
    |=> !m0_valid_out || m0_target_out == 4'h3) else $error("boot window missed");
  chk_fast_target: assert property (take && m0_addr_in[31:18] == 14'h0802
    |=> !m0_valid_out || m0_target_out == 4'h7) else $error("fast area missed");
  chk_slow_slot: assert property (take && m0_addr_in[31:20] == 12'h400
    |=> !m0_valid_out || m0_slot_out == {1'b0, prev_addr[19:14]}) else $error("slow slot wrong");
  chk_core_target: assert property (take && m0_addr_in[31:20] == 12'hE00
    |=> !m0_valid_out || m0_target_out == 4'hC) else $error("core region missed");
  chk_static_onehot: assert property ($onehot0(static_mem_select_out))
    else $error("static selects not one-hot");
  chk_dyn_onehot: assert property ($onehot0(dynamic_mem_select_out))
    else $error("dynamic selects not one-hot");
  // Main scenarios.
  cover property (m1_wait_out);
  cover property (m0_error_out);
  cover property (|dynamic_mem_select_out);
endmodule
bind sad_decoder sad_decoder_chk i_chk (.*);

// ==== tb/sad_master_model.sv ====
// Purpose: Behavioural bus master that issues one address at a time.
// Assumes: Requests are taken on the edge after they are raised.
// Notes: A released address shows its inverse, never the old value.
`timescale 1ns/1ps
module sad_master_model (
  // Clock and answers.
  input wire logic clk_in,
  input wire logic valid_in,
  input wire logic wait_in,
  // Request.
  output logic req_out = 1'b0,
  output logic [31:0] addr_out = 32'h0
);
  // Holds the request while it is stalled, then lets go.
  task automatic access(input logic [31:0] a, output int waits);
    @(posedge clk_in) #1;
    req_out = 1'b1;
    addr_out = a;
    waits = 0;
    @(posedge clk_in) #1;
    while (wait_in && waits < 20) begin
      waits++;
      @(posedge clk_in) #1;
    end
    // No answer at all is reported as a negative count.
    if (!valid_in && !wait_in) begin
      waits = -1;
    end
    req_out = 1'b0;
    addr_out = ~a;
  endtask
endmodule

// ==== tb/sad_decoder_tb.sv ====
// Purpose: Self-checking bench for the system address decoder.
// Assumes: Both masters are behavioural models on one clock.
// Notes: The clock enable is dropped once to show that the master 0 target and valid outputs freeze.
`timescale 1ns/1ps
module sad_decoder_tb;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [1:0] flash_size_in = 2'h3;
  logic [1:0] sram_size_in = 2'h2;
  logic remap_en_in = 1'b0;
  logic [1:0] remap_sel_in = 2'h0;
  logic m0_req_in, m0_valid_out, m0_wait_out, m0_error_out;
  logic m1_req_in, m1_valid_out, m1_wait_out, m1_error_out;
  logic [31:0] m0_addr_in, m1_addr_in, m0_offset_out, m1_offset_out;
  logic [3:0] m0_target_out, m1_target_out, static_mem_select_out, dynamic_mem_select_out;
  logic [1:0] m0_cs_out, m1_cs_out;
  logic [6:0] m0_slot_out, m1_slot_out;
  int mismatches = 0;
  int checks = 0;
  int w0, w1;
  // Clock and the parts under test.
  always #2.5 sys_clk_in = ~sys_clk_in;
  sad_decoder #(.VEC_BYTES(32'h00000200)) i_dut (.*);
  sad_master_model i_m0 (.clk_in(sys_clk_in), .valid_in(m0_valid_out), .wait_in(m0_wait_out),
    .req_out(m0_req_in), .addr_out(m0_addr_in));
  sad_master_model i_m1 (.clk_in(sys_clk_in), .valid_in(m1_valid_out), .wait_in(m1_wait_out),
    .req_out(m1_req_in), .addr_out(m1_addr_in));
  // Compares one value and counts the outcome.
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Sends one master 0 access and compares its target.
  task automatic probe(input logic [31:0] a, input logic [3:0] t);
    i_m0.access(a, w0);
    check("target", m0_target_out, t);
    check("valid", m0_valid_out, 1'b1);
    check("error", m0_error_out, t == 4'h0);
    check("m0 waits", w0, 0);
  endtask
  // Walks the top of each fitted flash and SRAM size.
  task automatic sc_sizes();
    logic [31:0] top;
    for (int s = 0; s < 4; s++) begin
      flash_size_in = s[1:0];
      top = 32'h00010000 << s;
      probe(top - 32'h4, 4'h1);
      probe(top, 4'h0);
      check("error", m0_error_out, 1'b1);
      check("offset", m0_offset_out, 32'h0);
    end
    // Size code 3 is expected to behave as the 64 kB window.
    for (int s = 0; s < 4; s++) begin
      sram_size_in = s[1:0];
      top = 32'h10000000 + (32'h00004000 << ((s > 2) ? 2 : s));
      probe(top - 32'h4, 4'h2);
      probe(top, 4'h0);
    end
  endtask
  // Checks both sides of the boot, peripheral SRAM, fast and slow area tops, then slot fields.
  task automatic sc_regions();
    logic [31:0] a [0:11] = '{32'h1FFF1FFC, 32'h1FFF2000, 32'h20000000, 32'h20002000,
      32'h20007FFC, 32'h20008000, 32'h200BFFFC, 32'h200C0000, 32'h4007FFFC, 32'h400FFFFC,
      32'h40100000, 32'hE00FFFFC};
    logic [3:0] t [0:11] = '{4'h3, 4'h0, 4'h4, 4'h5, 4'h6, 4'h0, 4'h7, 4'h0, 4'h8, 4'h9,
      4'h0, 4'hC};
    for (int i = 0; i < 12; i++)
      probe(a[i], t[i]);
    probe(32'h40084010, 4'h9);
    check("slot", m0_slot_out, 7'h21);
    check("offset", m0_offset_out, 32'h10);
    probe(32'h200BC004, 4'h7);
    check("slot", m0_slot_out, 7'h2F);
    check("offset", m0_offset_out, 32'h4);
  endtask
  // Drives the top of every external chip select window.
  task automatic sc_external();
    logic [7:0] sb [0:3] = '{8'h80, 8'h90, 8'h98, 8'h9C};
    for (int n = 0; n < 4; n++) begin
      probe({sb[n], 24'h0} + 32'h03FFFFFC, 4'hA);
      check("static", static_mem_select_out, 4'h1 << n);
      probe({4'hA + n[3:0], 28'hFFFFFFC}, 4'hB);
      check("cs", m0_cs_out, n[1:0]);
      check("dynamic", dynamic_mem_select_out, 4'h1 << n);
    end
    probe(32'h84000000, 4'h0);
  endtask
  // Redirects the vector area to each target.
  task automatic sc_remap();
    logic [3:0] t [0:3] = '{4'h3, 4'h2, 4'h1, 4'h1};
    remap_en_in = 1'b1;
    for (int s = 0; s < 4; s++) begin
      remap_sel_in = s[1:0];
      probe(32'h00000004, t[s]);
    end
    probe(32'h00000200, 4'h1);
    remap_en_in = 1'b0;
  endtask
  // Two collisions with alternating winner, then parallel access.
  task automatic sc_collide();
    for (int r = 0; r < 2; r++) begin
      fork
        i_m0.access(32'h10000010, w0);
        i_m1.access(32'h10000020, w1);
      join
      check("wait m0", w0, r);
      check("wait m1", w1, 1 - r);
    end
    fork
      i_m0.access(32'h00000100, w0);
      i_m1.access(32'h20000100, w1);
    join
    check("stalls", w0 + w1, 0);
  endtask
  // Sends DMA accesses alone and compares every field of its result.
  task automatic sc_dma();
    i_m1.access(32'hB0000004, w1);
    check("m1 valid", m1_valid_out, 1'b1);
    check("m1 target", m1_target_out, 4'hB);
    check("m1 cs", m1_cs_out, 2'h1);
    check("m1 offset", m1_offset_out, 32'h4);
    check("dynamic", dynamic_mem_select_out, 4'h2);
    check("m1 error", m1_error_out, 1'b0);
    i_m1.access(32'h40084010, w1);
    check("m1 slot", m1_slot_out, 7'h21);
    i_m1.access(32'h00090000, w1);
    check("m1 error", m1_error_out, 1'b1);
    check("m1 target", m1_target_out, 4'h0);
    check("m1 waits", w1, 0);
  endtask
  // Freezes the outputs with the enable low, then resets while still frozen.
  task automatic sc_freeze();
    probe(32'h1FFF0004, 4'h3);
    ce_in = 1'b0;
    i_m0.access(32'h00000100, w0);
    check("held target", m0_target_out, 4'h3);
    check("held valid", m0_valid_out, 1'b1);
    rst_in = 1'b1;
    @(posedge sys_clk_in) #1;
    rst_in = 1'b0;
    ce_in = 1'b1;
    check("reset valid", m0_valid_out, 1'b0);
    check("reset target", m0_target_out, 4'h0);
  endtask
  // Prints the counts and the verdict.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    sc_sizes();
    sc_regions();
    sc_external();
    sc_remap();
    sc_dma();
    sc_freeze();
    sc_collide();
    end_of_test();
  end
  // Watchdog against a hang.
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule
